// ### rtl/lcc_cluster.sv
// Cluster of eight logic cells sharing one local routing network
//
// How it works
// - Cell has table, register, carry, cascade
// - Four modes chosen by configuration
// - Seven inputs: data, feedback, carry, cascade
// - Clock, clear and preset drive register
// - Synchronous enable, optionally from data one
// - Carry or data three feeds table
// - Table result combines into cascade chain
// - Register or table feeds both routings
// - Separate local and row/column outputs
// - Data four loads register, three-input table
// - Table input also loads register
// - Packed register keeps enable, clear, preset
// - Output assignment swappable when packed
// - Eight cells share local routing network
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module lcc_cluster (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input lcc_pkg::lcc_bus_type bus,
  output logic [31:0] rd_data,
  // Routing and controls
  input wire logic [lcc_pkg::LCC_IN_W-1:0] cluster_in,
  input lcc_pkg::lcc_ctrl_type ctrl,
  input lcc_pkg::lcc_chain_type chain_in,
  // Cell outputs
  output logic [lcc_pkg::LCC_CELLS-1:0] local_out,
  output logic [lcc_pkg::LCC_CELLS-1:0] row_out,
  output lcc_pkg::lcc_chain_type chain_out
);
  import lcc_pkg::*;

  logic [LCC_WORDS-1:0][31:0] words;
  logic [31:0] status;
  logic [LCC_NET_W-1:0] net;
  lcc_cfg_type cfg [LCC_CELLS];
  logic [3:0] dat [LCC_CELLS];
  logic [LCC_CELLS-1:0] cq;
  logic [LCC_CELLS-1:0] clocal;
  logic [LCC_CELLS-1:0] crow;
  logic [LCC_CELLS:0] carry_chain;
  logic [LCC_CELLS:0] casc_chain;

  // ----------------------------------------
  // Configuration store and status
  // ----------------------------------------
  assign status = {16'h0000, row_out, cq};

  lcc_cfg_mem u_cfg_mem (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus(bus),
    .status(status),
    .rd_data(rd_data),
    .words(words)
  );

  // ----------------------------------------
  // Shared local network
  // ----------------------------------------
  // Registered cell outputs feed back, so no combinational loop can form
  assign net = {8'h00, cluster_in, local_out};
  assign carry_chain[0] = chain_in.carry;
  assign casc_chain[0] = chain_in.cascade;

  // ----------------------------------------
  // Cells
  // ----------------------------------------
  genvar i;
  genvar k;
  generate
    for (i = 0; i < LCC_CELLS; i++)
    begin : g_cell
      assign cfg[i] = lcc_cfg_type'(words[LCC_CFG_BASE + i]);
      for (k = 0; k < 4; k++)
      begin : g_pick
        assign dat[i][k] = net[words[LCC_SEL_BASE + i][k*LCC_SEL_W +: LCC_SEL_W]];
      end

      lcc_cell u_cell (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .cfg(cfg[i]),
        .data(dat[i]),
        .carry_in(carry_chain[i]),
        .cascade_in(casc_chain[i]),
        .ctrl(ctrl),
        .local_out(clocal[i]),
        .row_out(crow[i]),
        .carry_out(carry_chain[i+1]),
        .cascade_out(casc_chain[i+1]),
        .q(cq[i])
      );

      // ----------------------------------------
      // Per-cell checks
      // ----------------------------------------
      AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl.clr |=> !cq[i])
        else $error("register not cleared");

      AST_PRESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && ctrl.prn |=> cq[i])
        else $error("register not preset");

      AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && !ctrl.tick[cfg[i].clk_sel] |=> $stable(cq[i]))
        else $error("register changed without clock");

      AST_CE_DATA_INPUT_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && cfg[i].ena_from_d1 && !dat[i][0] |=> $stable(cq[i]))
        else $error("register loaded while disabled");

      AST_D4_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && (cfg[i].reg_src == LCC_REG_D4)
        && (cfg[i].mode == LCC_NORMAL) && !cfg[i].ena_from_d1
        && ctrl.tick[cfg[i].clk_sel] |=> cq[i] == $past(dat[i][3]))
        else $error("data four not loaded");

      AST_CASCADE_AND: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].casc_en && !cfg[i].casc_or && !casc_chain[i] |-> !casc_chain[i+1])
        else $error("cascade and passed a high");

      AST_CLEAR_WINS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl.clr && ctrl.prn |=> !cq[i])
        else $error("preset beat clear");

      AST_LOAD_LUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && (cfg[i].reg_src == LCC_REG_LUT)
        && (cfg[i].mode == LCC_NORMAL) && !cfg[i].ena_from_d1
        && !cfg[i].local_from_reg && ctrl.tick[cfg[i].clk_sel]
        |=> cq[i] == $past(clocal[i]))
        else $error("table result not loaded");

      AST_PIN_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && (cfg[i].reg_src == LCC_REG_PIN)
        && (cfg[i].mode == LCC_NORMAL) && !cfg[i].ena_from_d1
        && (cfg[i].pin_idx == 2'h0) && ctrl.tick[cfg[i].clk_sel]
        |=> cq[i] == $past(dat[i][0]))
        else $error("table input not loaded");

      AST_ENA_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && (cfg[i].reg_src == LCC_REG_D4)
        && (cfg[i].mode == LCC_NORMAL) && cfg[i].ena_from_d1
        && dat[i][0] && ctrl.tick[cfg[i].clk_sel]
        |=> cq[i] == $past(dat[i][3]))
        else $error("enabled register not loaded");

      AST_CLRCNT_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !ctrl.clr && !ctrl.prn && (cfg[i].mode == LCC_CLRCNT)
        && !cfg[i].ena_from_d1 && dat[i][1] && ctrl.tick[cfg[i].clk_sel]
        |=> !cq[i])
        else $error("counter not cleared by data two");

      AST_LOCAL_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].local_from_reg |-> clocal[i] == cq[i])
        else $error("local output not from register");

      AST_ROW_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].row_from_reg |-> crow[i] == cq[i])
        else $error("row output not from register");

      AST_SAME_SRC: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].local_from_reg == cfg[i].row_from_reg |-> clocal[i] == crow[i])
        else $error("both routings differ from one source");

      AST_CARRY_PASS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].mode == LCC_NORMAL |-> carry_chain[i+1] == carry_chain[i])
        else $error("normal mode carry not passed");

      AST_CASCADE_OR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg[i].casc_en && cfg[i].casc_or && casc_chain[i] |-> casc_chain[i+1])
        else $error("cascade or dropped a high");

      AST_NO_CASCADE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !cfg[i].casc_en && !cfg[i].local_from_reg |-> casc_chain[i+1] == clocal[i])
        else $error("cascade out not the table result");

      COV_PACKED: cover property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg[i].reg_src == LCC_REG_D4) && ctrl.tick[cfg[i].clk_sel] ##1 cq[i]);
    end
  endgenerate

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      local_out <= '0;
    end
    else
    begin
      local_out <= clocal;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      row_out <= '0;
    end
    else
    begin
      row_out <= crow;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chain_out <= '0;
    end
    else
    begin
      chain_out.carry <= carry_chain[LCC_CELLS];
      chain_out.cascade <= casc_chain[LCC_CELLS];
    end
  end

  // ----------------------------------------
  // Cluster checks
  // ----------------------------------------
  AST_ROW_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> row_out == $past(crow))
    else $error("row output not registered from cells");

  AST_LOCAL_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> local_out == $past(clocal))
    else $error("local output not registered from cells");

  AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && (bus.addr == LCC_STATUS_ADDR) |=> rd_data[7:0] == $past(cq))
    else $error("status read lost cell registers");

  AST_CARRY_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> chain_out.carry == $past(carry_chain[LCC_CELLS]))
    else $error("carry out not registered");

  AST_CASC_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> chain_out.cascade == $past(casc_chain[LCC_CELLS]))
    else $error("cascade out not registered");

  AST_STATUS_ROW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && (bus.addr == LCC_STATUS_ADDR)
    |=> (rd_data[15:8] == $past(row_out)) && (rd_data[31:16] == 16'h0000))
    else $error("status read lost row outputs");

  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !bus.rd |=> rd_data == 32'h00000000)
    else $error("read data stood without a read");

  AST_RD_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && (bus.addr > LCC_STATUS_ADDR) |=> rd_data == 32'h00000000)
    else $error("unmapped read returned data");

  AST_WR_STORE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.wr && (bus.addr < LCC_STATUS_ADDR)
    |=> words[$past(bus.addr[3:0])] == $past(bus.wdata))
    else $error("configuration word not stored");

  AST_WR_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus.wr && (bus.addr >= LCC_STATUS_ADDR) |=> $stable(words))
    else $error("unmapped write changed a word");

  COV_CLEAR: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.clr ##1 (cq == 8'h00));

  COV_CASCADE: cover property (@(posedge sys_clk) disable iff (!rst_b)
    casc_chain[LCC_CELLS] ##1 chain_out.cascade);

  COV_STATUS: cover property (@(posedge sys_clk) disable iff (!rst_b)
    bus.rd && (bus.addr == LCC_STATUS_ADDR) ##1 (rd_data != 32'h00000000));

endmodule : lcc_cluster

// ### rtl/lcc_pkg.sv
// Package of shared constants and types for the logic cell cluster
package lcc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int LCC_CELLS = 8;
  localparam int LCC_IN_W = 16;
  localparam int LCC_NET_W = 32;
  localparam int LCC_SEL_W = 5;
  localparam int LCC_ADDR_W = 5;
  localparam int LCC_WORDS = 16;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] LCC_CFG_BASE = 5'h00;
  localparam logic [4:0] LCC_SEL_BASE = 5'h08;
  localparam logic [4:0] LCC_STATUS_ADDR = 5'h10;
  localparam logic [31:0] LCC_WORD_RESET = 32'h00000000;
  localparam logic LCC_Q_RESET = 1'b0;

  // ----------------------------------------
  // Modes and sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    LCC_NORMAL,
    LCC_ARITH,
    LCC_UPDOWN,
    LCC_CLRCNT
  } lcc_mode_type;

  typedef enum logic [1:0] {
    LCC_REG_LUT,
    LCC_REG_D4,
    LCC_REG_PIN,
    LCC_REG_FEED
  } lcc_reg_src_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] spare;
    logic clk_sel;
    logic row_from_reg;
    logic local_from_reg;
    logic [1:0] pin_idx;
    lcc_reg_src_type reg_src;
    logic ena_from_d1;
    logic casc_or;
    logic casc_en;
    logic carry_as_in3;
    lcc_mode_type mode;
    logic [15:0] lut_mask;
  } lcc_cfg_type;

  typedef struct packed {
    logic [LCC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcc_bus_type;

  typedef struct packed {
    logic [1:0] tick;
    logic clr;
    logic prn;
  } lcc_ctrl_type;

  typedef struct packed {
    logic carry;
    logic cascade;
  } lcc_chain_type;

endpackage : lcc_pkg

// ### rtl/lcc_cfg_mem.sv
// Configuration word store with registered read port
`timescale 1ns/1ps
module lcc_cfg_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input lcc_pkg::lcc_bus_type bus,
  input wire logic [31:0] status,
  output logic [31:0] rd_data,
  // Stored words
  output logic [lcc_pkg::LCC_WORDS-1:0][31:0] words
);
  import lcc_pkg::*;

  // ----------------------------------------
  // Word writes
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      words <= '{default: LCC_WORD_RESET};
    end
    else if (bus.wr && (bus.addr < LCC_STATUS_ADDR))
    begin
      words[bus.addr[3:0]] <= bus.wdata;
    end
  end

  // ----------------------------------------
  // Reads, one cycle later
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= LCC_WORD_RESET;
    end
    else if (bus.rd && (bus.addr < LCC_STATUS_ADDR))
    begin
      rd_data <= words[bus.addr[3:0]];
    end
    else if (bus.rd && (bus.addr == LCC_STATUS_ADDR))
    begin
      rd_data <= status;
    end
    else
    begin
      rd_data <= LCC_WORD_RESET;
    end
  end

endmodule : lcc_cfg_mem

// ### rtl/lcc_cell.sv
// One configurable logic cell: lookup table, register and chains
`timescale 1ns/1ps
module lcc_cell (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Configuration
  input lcc_pkg::lcc_cfg_type cfg,
  // Data and chain inputs
  input wire logic [3:0] data,
  input wire logic carry_in,
  input wire logic cascade_in,
  // Register controls
  input lcc_pkg::lcc_ctrl_type ctrl,
  // Outputs
  output logic local_out,
  output logic row_out,
  output logic carry_out,
  output logic cascade_out,
  output logic q
);
  import lcc_pkg::*;

  logic in3;
  logic lut4;
  logic lut_out;
  logic sum;
  logic cry;
  logic ena;
  logic load;
  logic next_q;
  logic [3:0] idx;
  logic [2:0] idx3;

  // ----------------------------------------
  // Table and mode paths
  // ----------------------------------------
  always_comb
  begin
    in3 = cfg.carry_as_in3 ? carry_in : data[2];
    idx = {(cfg.reg_src == LCC_REG_D4) ? 1'b0 : data[3], in3, data[1], data[0]};
    lut4 = cfg.lut_mask[idx];
    idx3 = {carry_in, data[1], data[0]};
    if ((cfg.mode == LCC_UPDOWN) || (cfg.mode == LCC_CLRCNT))
    begin
      idx3 = {carry_in, data[0], q};
    end
    sum = cfg.lut_mask[{1'b0, idx3}];
    cry = cfg.lut_mask[{1'b1, idx3}];
    if (cfg.mode == LCC_NORMAL)
    begin
      lut_out = lut4;
      carry_out = carry_in;
    end
    else
    begin
      lut_out = sum;
      carry_out = cry;
    end
    if (!cfg.casc_en)
    begin
      cascade_out = lut_out;
    end
    else if (cfg.casc_or)
    begin
      cascade_out = lut_out | cascade_in;
    end
    else
    begin
      cascade_out = lut_out & cascade_in;
    end
  end

  // ----------------------------------------
  // Register source and enable
  // ----------------------------------------
  always_comb
  begin
    ena = !cfg.ena_from_d1 || data[0];
    load = ctrl.tick[cfg.clk_sel] && ena;
    case (cfg.reg_src)
      LCC_REG_D4: next_q = data[3];
      LCC_REG_PIN: next_q = idx[cfg.pin_idx];
      default: next_q = lut_out;
    endcase
    if ((cfg.mode == LCC_CLRCNT) && data[1])
    begin
      next_q = LCC_Q_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= LCC_Q_RESET;
    end
    else if (ctrl.clr)
    begin
      q <= 1'b0;
    end
    else if (ctrl.prn)
    begin
      q <= 1'b1;
    end
    else if (load)
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Two outputs
  // ----------------------------------------
  always_comb
  begin
    local_out = cfg.local_from_reg ? q : lut_out;
    row_out = cfg.row_from_reg ? q : lut_out;
  end

endmodule : lcc_cell

// ### bench/lcc_route_model.sv
// Model of the neighbouring cells and routing that feed the cluster
`timescale 1ns/1ps
module lcc_route_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Values the neighbours produce
  input wire logic [15:0] pat,
  input wire logic carry,
  input wire logic cascade,
  // Toward the cluster
  output logic [15:0] cluster_in,
  output lcc_pkg::lcc_chain_type chain_in
);
  import lcc_pkg::*;

  // ----------------------------------------
  // Registered neighbour outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cluster_in <= 16'h0000;
    end
    else
    begin
      cluster_in <= pat;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chain_in <= '0;
    end
    else
    begin
      chain_in <= '{carry: carry, cascade: cascade};
    end
  end
endmodule : lcc_route_model

// ### bench/lcc_cluster_bench.sv
// Self-checking bench for the logic cell cluster
`timescale 1ns/1ps
module lcc_cluster_bench;
  import lcc_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  lcc_bus_type bus = '0;
  lcc_ctrl_type ctrl = '0;
  logic [15:0] pat = 16'h0000;
  logic carry = 1'b0;
  logic cascade = 1'b0;
  logic [15:0] cluster_in;
  lcc_chain_type chain_in;
  lcc_chain_type chain_out;
  logic [7:0] local_out;
  logic [7:0] row_out;
  logic [31:0] rd_data;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  lcc_route_model i_model (.sys_clk(sys_clk), .rst_b(rst_b), .pat(pat), .carry(carry),
    .cascade(cascade), .cluster_in(cluster_in), .chain_in(chain_in));

  lcc_cluster i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
    .cluster_in(cluster_in), .ctrl(ctrl), .chain_in(chain_in), .local_out(local_out),
    .row_out(row_out), .chain_out(chain_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    compare(rd_data, exp);
  endtask : reg_rd

  // Drive the neighbours, let outputs settle, check cell 0 outputs and chain outputs
  task automatic step(input logic [15:0] p, input logic c, input logic s, input logic [3:0] e);
    @(posedge sys_clk);
    pat <= p;
    carry <= c;
    cascade <= s;
    repeat (4) @(posedge sys_clk);
    #1;
    compare({28'h0000000, local_out[0], row_out[0], chain_out.cascade, chain_out.carry},
      {28'h0000000, e});
  endtask : step

  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_rd(5'h00, 32'h00000000);
    reg_rd(5'h11, 32'h00000000);
    reg_wr(5'h08, 32'h0005A928);
    reg_wr(5'h00, 32'h00008000);
    reg_rd(5'h00, 32'h00008000);
    step(16'h000F, 1'b0, 1'b0, 4'b1100);
    step(16'h000E, 1'b0, 1'b0, 4'b0000);
    reg_wr(5'h00, 32'h00048000);
    step(16'h000F, 1'b0, 1'b0, 4'b0000);
    step(16'h000F, 1'b1, 1'b0, 4'b1101);
    for (int n = 1; n < 8; n++)
    begin
      reg_wr(5'(n), 32'h00180000);
    end
    reg_wr(5'h00, 32'h00088000);
    step(16'h000F, 1'b0, 1'b0, 4'b1100);
    step(16'h000F, 1'b0, 1'b1, 4'b1110);
    reg_wr(5'h00, 32'h00180000);
    step(16'h0000, 1'b0, 1'b1, 4'b0010);
    @(posedge sys_clk);
    ctrl.tick <= 2'b01;
    reg_wr(5'h00, 32'h08400001);
    step(16'h0008, 1'b0, 1'b0, 4'b1110);
    step(16'h0009, 1'b0, 1'b0, 4'b0100);
    reg_rd(5'h10, 32'h00000101);
    reg_wr(5'h00, 32'h04400001);
    step(16'h0000, 1'b0, 1'b0, 4'b0110);
    reg_wr(5'h00, 32'h04600001);
    step(16'h0008, 1'b0, 1'b0, 4'b0110);
    step(16'h0009, 1'b0, 1'b0, 4'b1000);
    @(posedge sys_clk);
    ctrl.clr <= 1'b1;
    step(16'h0009, 1'b0, 1'b0, 4'b0000);
    @(posedge sys_clk);
    ctrl.clr <= 1'b0;
    ctrl.prn <= 1'b1;
    step(16'h0001, 1'b0, 1'b0, 4'b1000);
    summarize();
  end
endmodule : lcc_cluster_bench
